// [shared/uart_ext_pkg.sv]
/*
  constants, states and carriers shared by the serial port extension block
  and its baud generator; assumes one system clock domain
*/
package uart_ext_pkg;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int unsigned    PHASE_W        = 16;
  localparam int unsigned    ACC_W          = 17;
  localparam logic [16:0]    ACC_RESET      = 17'h0_0000;
  localparam logic [4:0]     PRESCALE_RESET = 5'h00;
  localparam logic           MULT_SEL_RESET = 1'b0;

  // ****************************************
  // serial modes
  // ****************************************
  localparam logic [1:0]     MODE_1         = 2'h1;
  localparam logic [1:0]     MODE_2         = 2'h2;
  localparam logic [1:0]     MODE_3         = 2'h3;

  // ****************************************
  // reserved command bytes
  // ****************************************
  localparam logic [7:0]     CMD_ARM_BYTE   = 8'hFE;
  localparam logic [7:0]     CMD_SOFT_POR   = 8'hFE;
  localparam logic [7:0]     CMD_PROG_REQ   = 8'hFD;
  localparam logic [7:0]     BREAK_DATA     = 8'h00;

  // ****************************************
  // baud prescale terminal counts
  // ****************************************
  // modes 1/3: accumulator carries per 16x tick (2^19 / 2^16 slow, 2^17 / 2^16 fast)
  localparam logic [4:0]     ACC_DIV_SLOW   = 5'h07;
  localparam logic [4:0]     ACC_DIV_FAST   = 5'h01;
  // mode 2: system cycles per 16x tick
  localparam logic [4:0]     OSC_DIV_SLOW   = 5'h01;
  localparam logic [4:0]     OSC_DIV_FAST   = 5'h00;
  // reference oscillator that the sample settings assume
  localparam int unsigned    REF_CLK_HZ     = 978656;
  localparam logic [15:0]    INC_9600_FAST  = 16'h505B;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {CMD_IDLE, CMD_BRK1, CMD_ARMED, CMD_BRK2} cmd_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic       bit9;
    logic       stop_ok;
  } rx_word_s;

  typedef struct packed {
    logic rx;
    logic tx;
  } irq_src_s;

endpackage : uart_ext_pkg

// [verilog/uart_baud_gen.sv]
/*
  16x sampling tick generator: direct divider in mode 2, phase accumulator
  in modes 1 and 3; assumes synchronous control inputs
*/
`timescale 1ns/1ns
module uart_baud_gen
  import uart_ext_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                enable,
  input  wire logic [1:0]          serial_mode,
  input  wire logic                mult_sel,
  input  wire logic [PHASE_W-1:0]  phase_inc,
  output logic                     baud_tick
);

  // ****************************************
  // accumulator and prescaler
  // ****************************************
  logic [ACC_W-1:0] acc_q, acc_d;
  logic [4:0]       pre_q, pre_d;
  logic             tick_d;
  logic             step;
  logic [4:0]       term;

  always_comb
  begin
    acc_d  = ACC_RESET;
    pre_d  = pre_q;
    tick_d = 1'b0;
    step   = 1'b0;
    term   = mult_sel ? OSC_DIV_FAST : OSC_DIV_SLOW;
    if (!enable)
    begin
      pre_d = PRESCALE_RESET;
    end
    else
    begin
      if (serial_mode == MODE_2)
      begin
        step = 1'b1;
      end
      else
      begin
        acc_d = {1'b0, acc_q[PHASE_W-1:0]} + {1'b0, phase_inc};
        step  = acc_q[ACC_W-1];
        term  = mult_sel ? ACC_DIV_FAST : ACC_DIV_SLOW;
      end
      if (step)
      begin
        if (pre_q >= term)
        begin
          pre_d  = PRESCALE_RESET;
          tick_d = 1'b1;
        end
        else
        begin
          pre_d = pre_q + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q     <= ACC_RESET;
      pre_q     <= PRESCALE_RESET;
      baud_tick <= 1'b0;
    end
    else
    begin
      acc_q     <= acc_d;
      pre_q     <= pre_d;
      baud_tick <= tick_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_acc_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !enable |=> acc_q == ACC_RESET && pre_q == PRESCALE_RESET)
    else $error("accumulator not cleared while disabled");

  chk_mode2_fast: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (enable && mult_sel && serial_mode == MODE_2)[*2] |=> baud_tick)
    else $error("mode 2 fast tick missing");

endmodule : uart_baud_gen

// [verilog/uart_addr_filter_irq_baudgen.sv]
/*
  serial port extensions: multiprocessor address filter, masked receive and
  transmit interrupt flags, reserved break-framed command detector and baud
  tick generation. assumes a frame receiver that reports each received word
  as a one-cycle strobe with its stop status, and a transmitter that pulses
  when a word has gone out; all inputs synchronous to sys_clk.

// Overview of operation
// - filter on: ninth bit flags address
// - address word compared, interrupt only on match
// - non-matching addresses raise no receive interrupt
// - software holds an 8-bit own address
// - zero mask bits are don't-care
// - also match broadcast: own OR mask
// - masks enable receive and transmit interrupts
// - pending equals done flag AND mask
// - accepted word sets receive done flag
// - clearing receive flag clears its pending
// - sent word sets transmit flag; clear drops it
// - break, FEh, break, command arms command
// - other traffic cancels pending command
// - command FEh requests full soft reset
// - command FDh requests program loading
// - mode 2 rate from oscillator divide
// - modes 1/3 add increment into accumulator
// - modes 1/3 rate increment*clock/2^23, times four
// - tick is sixteen times bit rate
// - multiplier select clears on reset
// - settings assume 978.656 kHz clock
// - accepted nine-bit word loads ninth bit
// - missing stop bit raises framing error
*/
`timescale 1ns/1ns
module uart_addr_filter_irq_baudgen
(
  input  wire logic                             sys_clk,
  input  wire logic                             rst_n,
  input  wire logic                             baud_gen_enable,
  input  wire logic [1:0]                       serial_mode,
  input  wire logic                             baud_mult_wr,
  input  wire logic                             baud_mult_wdata,
  input  wire logic [uart_ext_pkg::PHASE_W-1:0] phase_increment_reg,
  input  wire logic                             address_filter_enable,
  input  wire logic [7:0]                       own_address_reg,
  input  wire logic [7:0]                       address_mask_reg,
  input  wire logic                             rx_irq_mask,
  input  wire logic                             tx_irq_mask,
  input  wire logic                             rx_word_valid,
  input  wire uart_ext_pkg::rx_word_s           rx_word,
  input  wire logic                             tx_word_done,
  input  wire logic                             rx_done_clr,
  input  wire logic                             tx_done_clr,
  input  wire logic                             framing_error_clr,
  output logic                                  baud_tick,
  output logic                                  baud_multiplier_sel,
  output logic                                  rx_done_flag,
  output logic                                  tx_done_flag,
  output logic                                  rx_irq_pending,
  output logic                                  tx_irq_pending,
  output uart_ext_pkg::irq_src_s                irq_source_reg,
  output logic [7:0]                            rx_byte,
  output logic                                  rx_ninth_bit,
  output logic                                  framing_error_flag,
  output logic                                  soft_reset_req,
  output logic                                  prog_load_req
);
  import uart_ext_pkg::*;

  // ****************************************
  // baud generation
  // ****************************************
  logic mult_sel_d;

  always_comb
  begin
    mult_sel_d = baud_mult_wr ? baud_mult_wdata : baud_multiplier_sel;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      baud_multiplier_sel <= MULT_SEL_RESET;
    end
    else
    begin
      baud_multiplier_sel <= mult_sel_d;
    end
  end

  // reference rate for settings such as 505Bh at 9600 baud
  uart_baud_gen u_baud (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .enable      (baud_gen_enable),
    .serial_mode (serial_mode),
    .mult_sel    (baud_multiplier_sel),
    .phase_inc   (phase_increment_reg),
    .baud_tick   (baud_tick)
  );

  // ****************************************
  // address filter
  // ****************************************
  logic       nine_bit;
  logic       is_break;
  logic       addr_hit;
  logic       bcast_hit;
  logic [7:0] bcast;
  logic       accept;

  always_comb
  begin
    nine_bit  = (serial_mode == MODE_2) || (serial_mode == MODE_3);
    is_break  = !rx_word.stop_ok && (rx_word.data == BREAK_DATA);
    addr_hit  = ((rx_word.data ^ own_address_reg) & address_mask_reg) == 8'h00;
    bcast     = own_address_reg | address_mask_reg;
    bcast_hit = ((rx_word.data ^ bcast) & bcast) == 8'h00;
    accept    = rx_word_valid && !rx_done_flag;
    if (address_filter_enable)
    begin
      if (nine_bit)
      begin
        accept = accept && rx_word.bit9 && (addr_hit || bcast_hit);
      end
      else
      begin
        accept = accept && rx_word.stop_ok;
      end
    end
  end

  // ****************************************
  // receive side flags
  // ****************************************
  logic       rx_done_d;
  logic       ferr_d;
  logic [7:0] rx_byte_d;
  logic       rx_ninth_d;

  always_comb
  begin
    rx_done_d  = rx_done_flag;
    ferr_d     = framing_error_flag;
    rx_byte_d  = rx_byte;
    rx_ninth_d = rx_ninth_bit;
    if (rx_done_clr)
    begin
      rx_done_d = 1'b0;
    end
    if (accept)
    begin
      rx_done_d  = 1'b1;
      rx_byte_d  = rx_word.data;
      rx_ninth_d = rx_word.bit9;
    end
    if (framing_error_clr)
    begin
      ferr_d = 1'b0;
    end
    if (rx_word_valid && !rx_word.stop_ok)
    begin
      ferr_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_done_flag       <= 1'b0;
      framing_error_flag <= 1'b0;
      rx_byte            <= 8'h00;
      rx_ninth_bit       <= 1'b0;
    end
    else
    begin
      rx_done_flag       <= rx_done_d;
      framing_error_flag <= ferr_d;
      rx_byte            <= rx_byte_d;
      rx_ninth_bit       <= rx_ninth_d;
    end
  end

  // ****************************************
  // transmit flag and interrupt pending
  // ****************************************
  logic     tx_done_d;
  irq_src_s pend_d;

  always_comb
  begin
    tx_done_d = tx_done_flag;
    if (tx_done_clr)
    begin
      tx_done_d = 1'b0;
    end
    if (tx_word_done)
    begin
      tx_done_d = 1'b1;
    end
    pend_d.rx = rx_done_d && rx_irq_mask;
    pend_d.tx = tx_done_d && tx_irq_mask;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_done_flag   <= 1'b0;
      rx_irq_pending <= 1'b0;
      tx_irq_pending <= 1'b0;
      irq_source_reg <= '0;
    end
    else
    begin
      tx_done_flag   <= tx_done_d;
      rx_irq_pending <= pend_d.rx;
      tx_irq_pending <= pend_d.tx;
      irq_source_reg <= pend_d;
    end
  end

  // ****************************************
  // reserved command detector
  // ****************************************
  cmd_state_e cmd_q, cmd_d;
  logic       por_d;
  logic       prog_d;

  // a break is the host holding the line low until framing fails
  always_comb
  begin
    cmd_d  = cmd_q;
    por_d  = 1'b0;
    prog_d = 1'b0;
    if (rx_word_valid)
    begin
      case (cmd_q)
        CMD_IDLE:
        begin
          cmd_d = is_break ? CMD_BRK1 : CMD_IDLE;
        end
        CMD_BRK1:
        begin
          if (is_break)
          begin
            cmd_d = CMD_BRK1;
          end
          else if (rx_word.stop_ok && rx_word.data == CMD_ARM_BYTE)
          begin
            cmd_d = CMD_ARMED;
          end
          else
          begin
            cmd_d = CMD_IDLE;
          end
        end
        CMD_ARMED:
        begin
          cmd_d = is_break ? CMD_BRK2 : CMD_IDLE;
        end
        CMD_BRK2:
        begin
          if (is_break)
          begin
            cmd_d = CMD_BRK1;
          end
          else
          begin
            cmd_d  = CMD_IDLE;
            por_d  = rx_word.stop_ok && rx_word.data == CMD_SOFT_POR;
            prog_d = rx_word.stop_ok && rx_word.data == CMD_PROG_REQ;
          end
        end
        default:
        begin
          cmd_d = CMD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_q          <= CMD_IDLE;
      soft_reset_req <= 1'b0;
      prog_load_req  <= 1'b0;
    end
    else
    begin
      cmd_q          <= cmd_d;
      soft_reset_req <= por_d;
      prog_load_req  <= prog_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_cmd_ready;
    cmd_q == CMD_BRK2;
  endsequence

  sequence s_good_byte(logic [7:0] code);
    rx_word_valid && rx_word.stop_ok && rx_word.data == code;
  endsequence

  chk_soft_reset_cmd: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_cmd_ready and s_good_byte(CMD_SOFT_POR) |=> soft_reset_req ##1 !soft_reset_req)
    else $error("soft reset command not honoured");

  chk_prog_cmd: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_cmd_ready and s_good_byte(CMD_PROG_REQ) |=> prog_load_req && !soft_reset_req)
    else $error("program request not honoured");

  chk_cmd_cancel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cmd_q == CMD_ARMED && rx_word_valid && !is_break |=> cmd_q == CMD_IDLE)
    else $error("stray word did not cancel command");

  chk_cmd_only_armed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    soft_reset_req || prog_load_req |-> $past(cmd_q) == CMD_BRK2)
    else $error("command fired without arming");

  chk_rx_pending_and: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_irq_pending == (rx_done_flag && $past(rx_irq_mask)))
    else $error("receive pending not flag and mask");

  chk_tx_pending_and: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_irq_pending == (tx_done_flag && $past(tx_irq_mask)))
    else $error("transmit pending not flag and mask");

  chk_rx_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_done_clr && !accept |=> !rx_done_flag && !rx_irq_pending)
    else $error("receive clear did not drop pending");

  chk_tx_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_word_done |=> tx_done_flag ##0 (tx_irq_pending == $past(tx_irq_mask)))
    else $error("transmit done not flagged");

  chk_addr_reject: assert property (@(posedge sys_clk) disable iff (!rst_n)
    address_filter_enable && nine_bit && rx_word_valid && !rx_done_flag
    && !(rx_word.bit9 && (addr_hit || bcast_hit)) && !rx_done_clr |=> !rx_done_flag)
    else $error("unmatched word accepted");

  chk_addr_accept: assert property (@(posedge sys_clk) disable iff (!rst_n)
    nine_bit && rx_word_valid && !rx_done_flag && rx_word.bit9 && addr_hit
    |=> rx_done_flag && rx_byte == $past(rx_word.data) && rx_ninth_bit)
    else $error("matched address not accepted");

  chk_fe_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_word_valid && !rx_word.stop_ok |=> framing_error_flag)
    else $error("framing error not flagged");

  chk_mult_sel_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> !baud_multiplier_sel)
    else $error("multiplier select not cleared by reset");

endmodule : uart_addr_filter_irq_baudgen

// [testbench/serial_peer_model.sv]
/*
  peer model: the host or peer controllers on the serial line, seen through
  the frame receiver as whole words, plus the transmitter's done pulse.
  assumes a free-running sys_clk; drives on its falling edge.
*/
`timescale 1ns/1ns
module serial_peer_model
  import uart_ext_pkg::*;
(
  input  wire logic sys_clk,
  output logic      rx_word_valid,
  output rx_word_s  rx_word,
  output logic      tx_word_done
);
  initial
  begin
    rx_word_valid = 1'b0;
    rx_word       = '0;
    tx_word_done  = 1'b0;
  end

  // one word, taken at the next rising edge; the bus then shows garbage
  task automatic send(input logic [7:0] data, input logic bit9, input logic stop_ok);
  begin
    @(negedge sys_clk);
    rx_word_valid = 1'b1;
    rx_word       = '{data, bit9, stop_ok};
    @(negedge sys_clk);
    rx_word_valid = 1'b0;
    rx_word       = ~rx_word;
  end
  endtask : send

  // line held low until the receiver sees no stop bit
  task automatic brk;
  begin
    send(BREAK_DATA, 1'b0, 1'b0);
  end
  endtask : brk

  // arming sequence followed directly by the command byte
  task automatic command(input logic [7:0] code);
  begin
    brk();
    send(CMD_ARM_BYTE, 1'b1, 1'b1);
    brk();
    send(code, 1'b1, 1'b1);
  end
  endtask : command

  task automatic tx_pulse;
  begin
    @(negedge sys_clk);
    tx_word_done = 1'b1;
    @(negedge sys_clk);
    tx_word_done = 1'b0;
  end
  endtask : tx_pulse
endmodule : serial_peer_model

// [testbench/tb.sv]
/*
  self-checking bench for the serial port extension block; all inputs change
  on the falling edge of sys_clk, outputs are judged at the falling edge.
*/
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module tb;
  import uart_ext_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic       sys_clk, rst_n, baud_gen_enable, baud_mult_wr, baud_mult_wdata;
  logic [1:0] serial_mode;
  logic [15:0] phase_increment_reg;
  logic       address_filter_enable, rx_irq_mask, tx_irq_mask;
  logic [7:0] own_address_reg, address_mask_reg, rx_byte;
  logic       rx_done_clr, tx_done_clr, framing_error_clr, rx_word_valid, tx_word_done;
  rx_word_s   rx_word;
  irq_src_s   irq_source_reg;
  logic       baud_tick, baud_multiplier_sel, rx_done_flag, tx_done_flag;
  logic       rx_irq_pending, tx_irq_pending, rx_ninth_bit, framing_error_flag;
  logic       soft_reset_req, prog_load_req;
  int         err_total, total_checks, cyc;
  localparam logic [7:0] FD [5] = '{8'hF0, 8'hF1, 8'hF2, 8'hFA, 8'hF0};
  localparam logic [4:0] F9 = 5'b0_1111;
  localparam logic [4:0] FX = 5'b0_1011;

  serial_peer_model peer (.sys_clk, .rx_word_valid, .rx_word, .tx_word_done);
  uart_addr_filter_irq_baudgen dut (
    .sys_clk, .rst_n, .baud_gen_enable, .serial_mode, .baud_mult_wr, .baud_mult_wdata,
    .phase_increment_reg, .address_filter_enable, .own_address_reg, .address_mask_reg,
    .rx_irq_mask, .tx_irq_mask, .rx_word_valid, .rx_word, .tx_word_done, .rx_done_clr,
    .tx_done_clr, .framing_error_clr, .baud_tick, .baud_multiplier_sel, .rx_done_flag,
    .tx_done_flag, .rx_irq_pending, .tx_irq_pending, .irq_source_reg, .rx_byte,
    .rx_ninth_bit, .framing_error_flag, .soft_reset_req, .prog_load_req);

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic close_out;
  begin
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask : close_out

  task automatic pulse(ref logic s);
  begin
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  end
  endtask : pulse

  task automatic t_rx_irq;
  begin
    serial_mode = MODE_2;
    rx_irq_mask = 1'b1;
    peer.send(8'hA5, 1'b1, 1'b1);
    `CHK(rx_done_flag, 1'b1)
    `CHK(rx_byte, 8'hA5)
    `CHK(rx_ninth_bit, 1'b1)
    `CHK(irq_source_reg.rx, 1'b1)
    rx_irq_mask = 1'b0;
    @(negedge sys_clk);
    `CHK(rx_irq_pending, 1'b0)
    rx_irq_mask = 1'b1;
    @(negedge sys_clk);
    `CHK(rx_irq_pending, 1'b1)
    pulse(rx_done_clr);
    `CHK({rx_done_flag, rx_irq_pending}, 2'b00)
    $display("test rx_irq done");
  end
  endtask : t_rx_irq

  task automatic t_tx_irq;
  begin
    tx_irq_mask = 1'b1;
    peer.tx_pulse();
    `CHK({tx_done_flag, tx_irq_pending, irq_source_reg.tx}, 3'b111)
    tx_irq_mask = 1'b0;
    @(negedge sys_clk);
    `CHK(tx_irq_pending, 1'b0)
    pulse(tx_done_clr);
    `CHK(tx_done_flag, 1'b0)
    $display("test tx_irq done");
  end
  endtask : t_tx_irq

  task automatic t_filter;
  begin
    address_filter_enable = 1'b1;
    own_address_reg = 8'hF0;
    address_mask_reg = 8'hFA;
    for (int m = 2; m <= 3; m++)
      for (int i = 0; i < 5; i++)
      begin
        serial_mode = 2'(m);
        peer.send(FD[i], F9[i], 1'b1);
        `CHK(rx_done_flag, FX[i])
        `CHK(rx_irq_pending, FX[i])
        pulse(rx_done_clr);
      end
    serial_mode = MODE_1;
    peer.send(8'hF0, 1'b1, 1'b0);
    `CHK({rx_done_flag, framing_error_flag}, 2'b01)
    pulse(framing_error_clr);
    address_filter_enable = 1'b0;
    $display("test filter done");
  end
  endtask : t_filter

  task automatic cmd_check(input logic s, input logic p);
  begin
    `CHK({soft_reset_req, prog_load_req}, {s, p})
    @(negedge sys_clk);
    `CHK({soft_reset_req, prog_load_req}, 2'b00)
  end
  endtask : cmd_check

  task automatic t_cmd;
  begin
    peer.command(CMD_SOFT_POR);
    cmd_check(1'b1, 1'b0);
    peer.command(CMD_PROG_REQ);
    cmd_check(1'b0, 1'b1);
    peer.command(8'h55);
    cmd_check(1'b0, 1'b0);
    peer.brk();
    peer.send(8'h55, 1'b1, 1'b1);
    peer.send(CMD_ARM_BYTE, 1'b1, 1'b1);
    peer.brk();
    peer.send(CMD_SOFT_POR, 1'b1, 1'b1);
    cmd_check(1'b0, 1'b0);
    `CHK(framing_error_flag, 1'b1)
    pulse(framing_error_clr);
    `CHK(framing_error_flag, 1'b0)
    pulse(rx_done_clr);
    $display("test cmd done");
  end
  endtask : t_cmd

  task automatic period(input logic [1:0] md, input logic sm, input logic [15:0] inc, input int exp);
    int n;
  begin
    serial_mode = md;
    phase_increment_reg = inc;
    baud_mult_wdata = sm;
    pulse(baud_mult_wr);
    `CHK(baud_multiplier_sel, sm)
    baud_gen_enable = 1'b1;
    n = 0;
    while (baud_tick !== 1'b1 && n < 300)
    begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (baud_tick !== 1'b1 && n < 300);
    `CHK(n, exp)
    baud_gen_enable = 1'b0;
  end
  endtask : period

  task automatic t_baud;
    int n;
  begin
    period(MODE_2, 1'b0, 16'h0000, 2);
    period(MODE_2, 1'b1, 16'h0000, 1);
    period(MODE_1, 1'b1, 16'h8000, 4);
    period(MODE_3, 1'b0, 16'h8000, 16);
    period(MODE_3, 1'b1, 16'h4000, 8);
    repeat (2) @(negedge sys_clk);
    n = 0;
    repeat (40)
    begin
      @(negedge sys_clk);
      n += int'(baud_tick === 1'b1);
    end
    `CHK(n, 0)
    $display("test baud done");
  end
  endtask : t_baud

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {rst_n, baud_gen_enable, baud_mult_wr, baud_mult_wdata} = '0;
    {address_filter_enable, rx_irq_mask, tx_irq_mask} = '0;
    {rx_done_clr, tx_done_clr, framing_error_clr} = '0;
    serial_mode = MODE_1;
    phase_increment_reg = INC_9600_FAST;
    own_address_reg = 8'h00;
    address_mask_reg = 8'h00;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    `CHK({baud_multiplier_sel, rx_done_flag, tx_done_flag}, 3'b000)
    t_rx_irq();
    t_tx_irq();
    t_filter();
    t_cmd();
    t_baud();
    close_out();
  end
endmodule : tb
